// [bench/scg_clock_ctrl_bench.sv]
// Self-checking bench for the system clock control block.
`timescale 1ns/1ns
`default_nettype none
module scg_clock_ctrl_bench;
  import scg_pkg::*;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0, idle_instr_i = 1'b0;
  logic wake_pin_i = 1'b0, bypass_usb_ref_i = 1'b0, slow_src_sel_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000, io_wdata_i = 16'h0000, rv, d;
  logic [3:0] dly = 4'h0;
  logic [15:0] io_rdata_o, cpu_port_en_o, periph1_en_o, periph2_en_o, pll_ctrl2_o, pll_ctrl4_o;
  logic [3:0] clock_output_pin_sel_o;
  logic [1:0] src_bypass_sel_o;
  logic cpu_asleep_o, pll_locked_i, src_pll_en_o, pll_pwrdn_o, sysclk_en_o, clock_output_pin_en_o;
  logic external_memory_interface_stop_req_o, uart_stop_req_o, external_memory_interface_stop_ack_i, uart_stop_ack_i;
  int num_errors = 0, n_checks = 0, cyc = 0;
  scg_clock_ctrl scg_clock_ctrl_i (.clk_sys_i, .sys_rst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
    .idle_instr_i, .wake_pin_i, .cpu_asleep_o, .pll_locked_i, .bypass_usb_ref_i, .slow_src_sel_i, .src_pll_en_o,
    .src_bypass_sel_o, .pll_pwrdn_o, .sysclk_en_o, .cpu_port_en_o, .periph1_en_o, .periph2_en_o, .clock_output_pin_en_o,
    .clock_output_pin_sel_o, .pll_ctrl2_o, .pll_ctrl4_o, .external_memory_interface_stop_req_o, .uart_stop_req_o, .external_memory_interface_stop_ack_i, .uart_stop_ack_i);
  scg_far_model scg_far_model_i (.clk_sys_i, .sys_rst_i, .dly_i(dly), .external_memory_interface_req_i(external_memory_interface_stop_req_o),
    .uart_req_i(uart_stop_req_o), .pwrdn_i(pll_pwrdn_o), .external_memory_interface_ack_o(external_memory_interface_stop_ack_i), .uart_ack_o(uart_stop_ack_i),
    .locked_o(pll_locked_i));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The whole run needs about 250 cycles; the ceiling leaves ample slack.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Strobes drop one cycle before the next access, so no signal is driven twice at one instant.
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    io_wr_i = 1'b1;
    io_addr_i = a;
    io_wdata_i = v;
    wt(1);
    io_wr_i = 1'b0;
    wt(1);
  endtask
  task automatic rd(input logic [15:0] a);
    io_rd_i = 1'b1;
    io_addr_i = a;
    wt(1);
    io_rd_i = 1'b0;
    rv = io_rdata_o;
    wt(1);
  endtask
  function automatic logic [15:0] en1(input logic [15:0] v, input logic granted);
    en1 = ~v;
    if (!granted) begin
      en1[SCG_EXTERNAL_MEMORY_INTERFACE_GATE_BIT] = 1'b1;
      en1[SCG_UART_GATE_BIT] = 1'b1;
    end
  endfunction
  initial begin
    void'($urandom(2));
    wt(12);
    sys_rst_i = 1'b0;
    chk(periph1_en_o & periph2_en_o & cpu_port_en_o, 16'hFFFF);
    chk({11'h0, sysclk_en_o, src_pll_en_o, clock_output_pin_en_o, external_memory_interface_stop_req_o, uart_stop_req_o}, 16'h0010);
    chk(16'(clock_output_pin_sel_o), 16'h000B);
    rd(16'h1C30);
    chk(rv, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      d = i == 0 ? 16'h7FFF : 16'($urandom) & 16'h7FFF;
      wr(SCG_PERIPH_GATE1_ADDR, d);
      wr(SCG_PERIPH_GATE2_ADDR, ~d);
      wt(1);
      chk(periph1_en_o, en1(d, 1'b0));
      chk(periph2_en_o, d);
    end
    $display("gating test done");
    dly = 4'($urandom_range(6));
    wr(SCG_CLK_STOP_ADDR, SCG_STOP_REQ_MASK);
    rv = 16'h0000;
    for (int i = 0; i < 40 && (rv & 16'h0022) != 16'h0022; i++) rd(SCG_CLK_STOP_ADDR);
    chk(rv & 16'h0022, 16'h0022);
    chk({14'h0, external_memory_interface_stop_req_o, uart_stop_req_o}, 16'h0003);
    wr(SCG_PERIPH_GATE1_ADDR, 16'h7FFF);
    wt(1);
    chk(periph1_en_o, en1(16'h7FFF, 1'b1));
    chk(16'(sysclk_en_o), 16'h0001);
    wr(SCG_PERIPH_GATE1_ADDR, 16'h0000);
    wr(SCG_CLK_STOP_ADDR, 16'h0000);
    $display("handshake test done");
    wr(SCG_PLL_CTRL1_ADDR, 16'h1000);
    wr(SCG_SRC_SELECT_ADDR, 16'h0001);
    wt(1);
    chk({14'h0, pll_pwrdn_o, src_pll_en_o}, 16'h0002);
    wr(SCG_SRC_SELECT_ADDR, 16'h0000);
    d = 16'($urandom);
    wr(SCG_PLL_CTRL2_ADDR, d);
    wr(SCG_PLL_CTRL3_ADDR, d);
    wr(SCG_PLL_CTRL4_ADDR, ~d);
    wr(SCG_PLL_CTRL1_ADDR, 16'h0000);
    rv = 16'h0000;
    for (int i = 0; i < 150 && rv[SCG_LOCK_MON_BIT] !== 1'b1; i++) rd(SCG_PLL_CTRL3_ADDR);
    chk(rv & 16'h0008, 16'h0008);
    chk(pll_ctrl2_o, d);
    chk(rv & 16'hFFF7, d & 16'hFFF7);
    chk(pll_ctrl4_o, ~d);
    for (int m = 1; m >= 0; m--) begin
      wr(SCG_SRC_SELECT_ADDR, 16'(m));
      wt(1);
      chk(16'(src_pll_en_o), 16'(m));
    end
    for (int m = SCG_SRC_RTC; m <= SCG_SRC_USB; m++) begin
      bypass_usb_ref_i = m == SCG_SRC_USB;
      slow_src_sel_i = m == SCG_SRC_RTC;
      wt(3);
      chk(16'(src_bypass_sel_o), 16'(m));
    end
    for (int k = 0; k < 2; k++) begin
      wr(SCG_CLOCK_OUTPUT_PIN_SEL_ADDR, k == 0 ? 16'h000F : 16'h000B);
      wt(1);
      chk(16'(clock_output_pin_sel_o), k == 0 ? 16'h000F : 16'h000B);
    end
    wr(SCG_CPU_STATUS3_ADDR, 16'h0004 & 16'hFFFB);
    wt(1);
    chk(16'(clock_output_pin_en_o), 16'h0001);
    $display("source test done");
    wr(SCG_IDLE_CONFIG_ADDR, 16'h03EF);
    idle_instr_i = 1'b1;
    wt(1);
    idle_instr_i = 1'b0;
    wt(2);
    chk(16'(cpu_asleep_o), 16'h0001);
    chk(cpu_port_en_o, ~16'h03EF);
    wr(SCG_PERIPH_GATE1_ADDR, 16'h8000);
    wt(1);
    chk(16'(sysclk_en_o), 16'h0000);
    wake_pin_i = 1'b1;
    wt(3);
    chk({cpu_port_en_o[14:0], sysclk_en_o}, 16'hFFFF);
    chk(16'(cpu_asleep_o), 16'h0000);
    wake_pin_i = 1'b0;
    $display("idle test done");
    summarize();
  end
endmodule
`default_nettype wire

// [bench/scg_clock_ctrl_checker.sv]
// Port-level assertions for the system clock control block.
`timescale 1ns/1ns
`default_nettype none
module scg_clock_ctrl_checker
  import scg_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic        io_wr_i,
  input wire logic [15:0] io_wdata_i,
  input wire logic        idle_instr_i,
  input wire logic        wake_pin_i,
  input wire logic        cpu_asleep_o,
  input wire logic        pll_locked_i,
  input wire logic        src_pll_en_o,
  input wire logic        pll_pwrdn_o,
  input wire logic [15:0] periph1_en_o,
  input wire logic [15:0] periph2_en_o,
  input wire logic [3:0]  clock_output_pin_sel_o,
  input wire logic        external_memory_interface_stop_req_o,
  input wire logic        external_memory_interface_stop_ack_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_gate2;
    io_wr_i && io_addr_i == SCG_PERIPH_GATE2_ADDR |-> ##2 periph2_en_o == ~$past(io_wdata_i, 2);
  endproperty
  a_gate2: assert property (p_gate2) else $error("gate two enables miss the write");
  property p_req;
    io_wr_i && io_addr_i == SCG_CLK_STOP_ADDR |-> ##2 external_memory_interface_stop_req_o == $past(io_wdata_i[0], 2);
  endproperty
  a_req: assert property (p_req) else $error("stop request misses the write");
  property p_gated; $fell(periph1_en_o[SCG_EXTERNAL_MEMORY_INTERFACE_GATE_BIT]) |-> external_memory_interface_stop_ack_i; endproperty
  a_gated: assert property (p_gated) else $error("memory clock stopped without grant");
  property p_held; !external_memory_interface_stop_req_o [*4] |-> periph1_en_o[SCG_EXTERNAL_MEMORY_INTERFACE_GATE_BIT]; endproperty
  a_held: assert property (p_held) else $error("memory clock off with no request");
  property p_sleep; $rose(cpu_asleep_o) |-> $past(idle_instr_i) || $past(idle_instr_i, 2); endproperty
  a_sleep: assert property (p_sleep) else $error("core slept without idle");
  property p_wake; wake_pin_i [*2] |=> !cpu_asleep_o; endproperty
  a_wake: assert property (p_wake) else $error("wake pin did not wake the core");
  property p_sel;
    io_wr_i && io_addr_i == SCG_CLOCK_OUTPUT_PIN_SEL_ADDR |-> ##2 clock_output_pin_sel_o == $past(io_wdata_i[3:0], 2);
  endproperty
  a_sel: assert property (p_sel) else $error("clock output select misses the write");
  property p_pll; $rose(src_pll_en_o) |-> $past(pll_locked_i && !pll_pwrdn_o); endproperty
  a_pll: assert property (p_pll) else $error("PLL chosen while unlocked or off");
endmodule
bind scg_clock_ctrl scg_clock_ctrl_checker scg_clock_ctrl_checker_i (.clk_sys_i, .sys_rst_i, .io_addr_i, .io_wr_i,
  .io_wdata_i, .idle_instr_i, .wake_pin_i, .cpu_asleep_o, .pll_locked_i, .src_pll_en_o, .pll_pwrdn_o, .periph1_en_o,
  .periph2_en_o, .clock_output_pin_sel_o, .external_memory_interface_stop_req_o, .external_memory_interface_stop_ack_i);
`default_nettype wire

// [bench/scg_far_model.sv]
// Behavioural peripherals and PLL facing the clock control block.
`timescale 1ns/1ns
`default_nettype none
module scg_far_model (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       external_memory_interface_req_i,
  input  wire logic       uart_req_i,
  input  wire logic       pwrdn_i,
  output logic            external_memory_interface_ack_o,
  output logic            uart_ack_o,
  output logic            locked_o
);
  logic [3:0] external_memory_interface_cnt_r, uart_cnt_r;
  logic [6:0] lock_cnt_r;
  // Counters saturate, so a request held for long keeps its grant.
  always_ff @(posedge clk_sys_i) begin
    external_memory_interface_cnt_r <= (sys_rst_i || !external_memory_interface_req_i) ? 4'h0 : external_memory_interface_cnt_r + {3'h0, external_memory_interface_cnt_r != 4'hF};
    uart_cnt_r <= (sys_rst_i || !uart_req_i) ? 4'h0 : uart_cnt_r + {3'h0, uart_cnt_r != 4'hF};
    lock_cnt_r <= (sys_rst_i || pwrdn_i) ? 7'h0 : lock_cnt_r + {6'h0, !locked_o};
  end
  assign external_memory_interface_ack_o = external_memory_interface_req_i && external_memory_interface_cnt_r >= dly_i;
  assign uart_ack_o = uart_req_i && uart_cnt_r >= dly_i;
  assign locked_o = lock_cnt_r == 7'h50;
endmodule
`default_nettype wire

// [logic/scg_clock_ctrl.sv]
// System clock source selection, PLL control and per-module clock gating.
`timescale 1ns/1ns
`default_nettype none

module scg_clock_ctrl
  import scg_pkg::*;
(
  // System clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // Register port on the I/O space
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [15:0] io_wdata_i,
  output logic      [15:0] io_rdata_o,
  // CPU idle handshake
  input  wire logic        idle_instr_i,
  input  wire logic        wake_pin_i,
  output logic             cpu_asleep_o,
  // Source and PLL status from the analog clock generator
  input  wire logic        pll_locked_i,
  input  wire logic        bypass_usb_ref_i,
  input  wire logic        slow_src_sel_i,
  // Clock enables for the glitch-free cells
  output logic             src_pll_en_o,
  output logic [1:0]       src_bypass_sel_o,
  output logic             pll_pwrdn_o,
  output logic             sysclk_en_o,
  output logic [15:0]      cpu_port_en_o,
  output logic [15:0]      periph1_en_o,
  output logic [15:0]      periph2_en_o,
  output logic             clock_output_pin_en_o,
  output logic [3:0]       clock_output_pin_sel_o,
  // PLL settings towards the analog block
  output logic [15:0]      pll_ctrl2_o,
  output logic [15:0]      pll_ctrl4_o,
  // Stop handshake with the memory interface and UART
  output logic             external_memory_interface_stop_req_o,
  output logic             uart_stop_req_o,
  input  wire logic        external_memory_interface_stop_ack_i,
  input  wire logic        uart_stop_ack_i
);

  logic [15:0] idle_cfg_r;
  logic [15:0] cpu_st3_r;
  logic [15:0] gate1_r;
  logic [15:0] gate2_r;
  logic        src_pll_r;
  logic [15:0] pll_ctrl1_r;
  logic [15:0] pll_ctrl2_r;
  logic [15:0] pll_ctrl3_r;
  logic [15:0] pll_ctrl4_r;
  logic [3:0]  clock_output_pin_sel_r;
  logic [15:0] stop_r;
  logic        lock_mon_r;
  logic [15:0] lock_cnt_r;
  logic        asleep_r;
  logic        sysclk_on_r;
  logic        external_memory_interface_grant_r;
  logic        uart_grant_r;
  wire logic [15:0] periph1_nxt;

  function automatic logic wr_hit(input logic [15:0] a);
    return io_wr_i && (io_addr_i == a);
  endfunction

  // Software-owned registers, one block per register; all gates reset open.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      idle_cfg_r <= SCG_ZERO_RST;
    end else if (wr_hit(SCG_IDLE_CONFIG_ADDR)) begin
      idle_cfg_r <= io_wdata_i;
    end
  end

  // The clock output pin stays off after reset until software clears its disable bit.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cpu_st3_r <= SCG_CPU_STATUS3_RST;
    end else if (wr_hit(SCG_CPU_STATUS3_ADDR)) begin
      cpu_st3_r <= io_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      gate1_r <= SCG_GATE_RST;
    end else if (wr_hit(SCG_PERIPH_GATE1_ADDR)) begin
      gate1_r <= io_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      gate2_r <= SCG_GATE_RST;
    end else if (wr_hit(SCG_PERIPH_GATE2_ADDR)) begin
      gate2_r <= io_wdata_i;
    end
  end

  // Only the source bit is stored; the other bits of that register read back as zero.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      src_pll_r <= 1'b0;
    end else if (wr_hit(SCG_SRC_SELECT_ADDR)) begin
      src_pll_r <= io_wdata_i[SCG_SRC_PLL_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pll_ctrl1_r <= SCG_ZERO_RST;
    end else if (wr_hit(SCG_PLL_CTRL1_ADDR)) begin
      pll_ctrl1_r <= io_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pll_ctrl2_r <= SCG_ZERO_RST;
    end else if (wr_hit(SCG_PLL_CTRL2_ADDR)) begin
      pll_ctrl2_r <= io_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pll_ctrl3_r <= SCG_ZERO_RST;
    end else if (wr_hit(SCG_PLL_CTRL3_ADDR)) begin
      pll_ctrl3_r <= io_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pll_ctrl4_r <= SCG_ZERO_RST;
    end else if (wr_hit(SCG_PLL_CTRL4_ADDR)) begin
      pll_ctrl4_r <= io_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      clock_output_pin_sel_r <= SCG_CLOCK_OUTPUT_PIN_SEL_RST[3:0];
    end else if (wr_hit(SCG_CLOCK_OUTPUT_PIN_SEL_ADDR)) begin
      clock_output_pin_sel_r <= io_wdata_i[3:0];
    end
  end

  // Only the two request bits are stored; the grant bits are derived from the acknowledges.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stop_r <= SCG_ZERO_RST;
    end else if (wr_hit(SCG_CLK_STOP_ADDR)) begin
      stop_r <= io_wdata_i & SCG_STOP_REQ_MASK;
    end
  end

  // Lock monitor: restarts whenever the PLL is powered down or PLL control register 1 is written.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lock_cnt_r <= 16'h0000;
      lock_mon_r <= 1'b0;
    end else if (pll_ctrl1_r[SCG_PLL_PWRDN_BIT] || wr_hit(SCG_PLL_CTRL1_ADDR)) begin
      lock_cnt_r <= 16'h0000;
      lock_mon_r <= 1'b0;
    end else if (lock_cnt_r < 16'(SCG_PLL_LOCK_CYCLES)) begin
      lock_cnt_r <= lock_cnt_r + 16'h0001;
    end else begin
      lock_mon_r <= pll_locked_i;
    end
  end

  // Grants follow the modules' acknowledges; a dropped request withdraws its grant.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      external_memory_interface_grant_r <= 1'b0;
      uart_grant_r <= 1'b0;
    end else begin
      external_memory_interface_grant_r <= stop_r[SCG_EXTERNAL_MEMORY_INTERFACE_REQ_BIT] && external_memory_interface_stop_ack_i;
      uart_grant_r <= stop_r[SCG_UART_REQ_BIT] && uart_stop_ack_i;
    end
  end

  // CPU idle: gating takes effect only on the idle instruction after configuration.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      asleep_r <= 1'b0;
    end else if (wake_pin_i) begin
      asleep_r <= 1'b0;
    end else if (idle_instr_i && idle_cfg_r[SCG_IDLE_CPU_BIT]) begin
      asleep_r <= 1'b1;
    end
  end

  // System clock branch: gated by bit 15, reopened by the wake pin.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sysclk_on_r <= 1'b1;
    end else if (wake_pin_i) begin
      sysclk_on_r <= 1'b1;
    end else if (wr_hit(SCG_PERIPH_GATE1_ADDR)) begin
      sysclk_on_r <= !io_wdata_i[SCG_SYSCLK_GATE_BIT];
    end
  end

  // Per-bit peripheral enables; the two handshake bits also wait for their grant.
  for (genvar g = 0; g < 16; g++) begin : g_periph1
    if (g == SCG_EXTERNAL_MEMORY_INTERFACE_GATE_BIT) begin : g_external_memory_interface
      assign periph1_nxt[g] = !(gate1_r[g] && external_memory_interface_grant_r);
    end else if (g == SCG_UART_GATE_BIT) begin : g_uart
      assign periph1_nxt[g] = !(gate1_r[g] && uart_grant_r);
    end else begin : g_plain
      assign periph1_nxt[g] = !gate1_r[g];
    end
  end

  // Source mux controls; the PLL is chosen only when powered and locked, so the mux never sees a dead clock.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      src_pll_en_o     <= 1'b0;
      src_bypass_sel_o <= 2'(SCG_SRC_RTC);
      pll_pwrdn_o      <= 1'b0;
    end else begin
      src_pll_en_o <= src_pll_r && lock_mon_r && !pll_ctrl1_r[SCG_PLL_PWRDN_BIT];
      if (bypass_usb_ref_i) begin
        src_bypass_sel_o <= 2'(SCG_SRC_USB);
      end else if (slow_src_sel_i) begin
        src_bypass_sel_o <= 2'(SCG_SRC_RTC);
      end else begin
        src_bypass_sel_o <= 2'(SCG_SRC_EXT);
      end
      pll_pwrdn_o <= pll_ctrl1_r[SCG_PLL_PWRDN_BIT];
    end
  end

  // Enables to the latch-based gate cells of the CPU side; registering them keeps edges clean.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sysclk_en_o   <= 1'b1;
      cpu_port_en_o <= 16'hFFFF;
      cpu_asleep_o  <= 1'b0;
    end else begin
      sysclk_en_o   <= sysclk_on_r;
      cpu_port_en_o <= asleep_r ? ~idle_cfg_r : 16'hFFFF;
      cpu_asleep_o  <= asleep_r;
    end
  end

  // Peripheral gate enables; a cleared gating bit means the clock runs.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      periph1_en_o <= 16'hFFFF;
      periph2_en_o <= 16'hFFFF;
    end else begin
      periph1_en_o <= periph1_nxt;
      periph2_en_o <= ~gate2_r;
    end
  end

  // Clock output pin; it is meant for debug, so it stays off until software enables it.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      clock_output_pin_en_o  <= 1'b0;
      clock_output_pin_sel_o <= SCG_CLOCK_OUTPUT_PIN_SEL_RST[3:0];
    end else begin
      clock_output_pin_en_o  <= !cpu_st3_r[SCG_CLOCK_OUTPUT_PIN_DIS_BIT];
      clock_output_pin_sel_o <= clock_output_pin_sel_r;
    end
  end

  // Stop requests to the memory interface and UART.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      external_memory_interface_stop_req_o <= 1'b0;
      uart_stop_req_o <= 1'b0;
    end else begin
      external_memory_interface_stop_req_o <= stop_r[SCG_EXTERNAL_MEMORY_INTERFACE_REQ_BIT];
      uart_stop_req_o <= stop_r[SCG_UART_REQ_BIT];
    end
  end

  // PLL settings towards the analog block, one cycle behind the register.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pll_ctrl2_o <= SCG_ZERO_RST;
      pll_ctrl4_o <= SCG_ZERO_RST;
    end else begin
      pll_ctrl2_o <= pll_ctrl2_r;
      pll_ctrl4_o <= pll_ctrl4_r;
    end
  end

  // Read data, one cycle after the read strobe; unmapped addresses read zero.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      io_rdata_o <= 16'h0000;
    end else if (io_rd_i) begin
      unique case (io_addr_i)
        SCG_IDLE_CONFIG_ADDR:  io_rdata_o <= idle_cfg_r;
        SCG_CPU_STATUS3_ADDR:  io_rdata_o <= cpu_st3_r;
        SCG_PERIPH_GATE1_ADDR: io_rdata_o <= gate1_r;
        SCG_PERIPH_GATE2_ADDR: io_rdata_o <= gate2_r;
        SCG_SRC_SELECT_ADDR:   io_rdata_o <= {15'h0, src_pll_r};
        SCG_PLL_CTRL1_ADDR:    io_rdata_o <= pll_ctrl1_r;
        SCG_PLL_CTRL2_ADDR:    io_rdata_o <= pll_ctrl2_r;
        SCG_PLL_CTRL3_ADDR:    io_rdata_o <= {pll_ctrl3_r[15:4], lock_mon_r, pll_ctrl3_r[2:0]};
        SCG_PLL_CTRL4_ADDR:    io_rdata_o <= pll_ctrl4_r;
        SCG_CLOCK_OUTPUT_PIN_SEL_ADDR:   io_rdata_o <= {12'h000, clock_output_pin_sel_r};
        SCG_CLK_STOP_ADDR:     io_rdata_o <= {10'h0, uart_grant_r, stop_r[4], 2'b00,
                                              external_memory_interface_grant_r, stop_r[0]};
        default:               io_rdata_o <= 16'h0000;
      endcase
    end else begin
      io_rdata_o <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// [pkg/scg_pkg.sv]
// Package of register offsets, field positions and reset values for the system clock control block.
`default_nettype none
package scg_pkg;
  // Register addresses on the I/O space.
  localparam logic [15:0] SCG_IDLE_CONFIG_ADDR   = 16'h0001;
  localparam logic [15:0] SCG_CPU_STATUS3_ADDR   = 16'h0004;
  localparam logic [15:0] SCG_PERIPH_GATE1_ADDR  = 16'h1C02;
  localparam logic [15:0] SCG_PERIPH_GATE2_ADDR  = 16'h1C03;
  localparam logic [15:0] SCG_SRC_SELECT_ADDR    = 16'h1C1F;
  localparam logic [15:0] SCG_PLL_CTRL1_ADDR     = 16'h1C20;
  localparam logic [15:0] SCG_PLL_CTRL2_ADDR     = 16'h1C21;
  localparam logic [15:0] SCG_PLL_CTRL3_ADDR     = 16'h1C22;
  localparam logic [15:0] SCG_PLL_CTRL4_ADDR     = 16'h1C23;
  localparam logic [15:0] SCG_CLOCK_OUTPUT_PIN_SEL_ADDR    = 16'h1C24;
  localparam logic [15:0] SCG_CLK_STOP_ADDR      = 16'h1C3A;
  // Field positions.
  localparam int SCG_SRC_PLL_BIT       = 0;
  localparam int SCG_PLL_PWRDN_BIT     = 12;
  localparam int SCG_LOCK_MON_BIT      = 3;
  localparam int SCG_SYSCLK_GATE_BIT   = 15;
  localparam int SCG_EXTERNAL_MEMORY_INTERFACE_GATE_BIT     = 11;
  localparam int SCG_UART_GATE_BIT     = 2;
  localparam int SCG_EXTERNAL_MEMORY_INTERFACE_REQ_BIT      = 0;
  localparam int SCG_EXTERNAL_MEMORY_INTERFACE_ACK_BIT      = 1;
  localparam int SCG_UART_REQ_BIT      = 4;
  localparam int SCG_UART_ACK_BIT      = 5;
  localparam int SCG_CLOCK_OUTPUT_PIN_DIS_BIT    = 2;
  localparam int SCG_IDLE_CPU_BIT      = 0;
  // Clock output source codes.
  localparam logic [3:0]  SCG_CLOCK_OUTPUT_PIN_USB_PHY     = 4'hF;
  localparam logic [3:0]  SCG_CLOCK_OUTPUT_PIN_DSP         = 4'hB;
  // Reset values: every gate open, PLL bypassed and powered, clock output off.
  localparam logic [15:0] SCG_GATE_RST           = 16'h0000;
  localparam logic [15:0] SCG_ZERO_RST           = 16'h0000;
  localparam logic [15:0] SCG_CPU_STATUS3_RST    = 16'h0004;
  localparam logic [15:0] SCG_CLOCK_OUTPUT_PIN_SEL_RST     = 16'h000B;
  localparam logic [15:0] SCG_STOP_REQ_MASK      = 16'h0011;
  // PLL lock time and the derived cycle count at 250 MHz (4 ns period).
  localparam int SCG_CLK_PERIOD_NS     = 4;
  localparam int SCG_PLL_LOCK_NS       = 400;
  localparam int SCG_PLL_LOCK_CYCLES   = (SCG_PLL_LOCK_NS + SCG_CLK_PERIOD_NS - 1) / SCG_CLK_PERIOD_NS;
  // Stop grace cycles; no logic uses this constant, and the grant waits only for the module's acknowledge.
  localparam int SCG_STOP_ACK_CYCLES   = 4;
  localparam int SCG_SRC_RTC           = 0;
  localparam int SCG_SRC_EXT           = 1;
  localparam int SCG_SRC_USB           = 2;
endpackage
`default_nettype wire
